// >>> hw/rtcbv_pkg.sv
// Constants, field layout and types shared by the time and alarm value view block.
// Assumes a 32-bit APB register port and 16-bit BCD value views.
package rtcbv_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VIEW_W = 16;
    localparam int MEM_AW = 3;
    localparam int MEM_DEPTH = 8;

    // Register byte offsets on the APB port.
    localparam logic [ADDR_W-1:0] OFS_CONFIG       = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ALARM_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TIME_VALUE   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ALARM_VALUE  = 8'h0c;

    // Control field positions and reset values.
    localparam int POS_WRITE_ENABLE = 13;
    localparam int POS_POINTER      = 8;
    localparam logic       RST_WRITE_ENABLE = 1'b0;
    localparam logic [1:0] RST_POINTER      = 2'h0;

    // View pointer codes.
    localparam logic [1:0] PTR_MIN_SEC    = 2'h0;
    localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR  = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY  = 2'h2;
    localparam logic [1:0] PTR_YEAR       = 2'h3;

    // Digit positions inside the 16-bit views.
    localparam int POS_MONTH_TENS  = 12;
    localparam int POS_MONTH_ONES  = 8;
    localparam int POS_DAY_TENS    = 4;
    localparam int POS_DAY_ONES    = 0;
    localparam int POS_WEEKDAY     = 8;
    localparam int POS_HOUR_TENS   = 4;
    localparam int POS_HOUR_ONES   = 0;
    localparam int POS_MINUTE_TENS = 12;
    localparam int POS_MINUTE_ONES = 8;
    localparam int POS_SECOND_TENS = 4;
    localparam int POS_SECOND_ONES = 0;

    // Implemented bits of each view; everything else reads as zero.
    localparam logic [VIEW_W-1:0] MASK_MONTH_DAY =
        (16'h0001 << POS_MONTH_TENS) | (16'h000f << POS_MONTH_ONES) |
        (16'h0003 << POS_DAY_TENS) | (16'h000f << POS_DAY_ONES);
    localparam logic [VIEW_W-1:0] MASK_WEEKDAY_DIGIT_HOUR =
        (16'h0007 << POS_WEEKDAY) | (16'h0003 << POS_HOUR_TENS) |
        (16'h000f << POS_HOUR_ONES);
    localparam logic [VIEW_W-1:0] MASK_MIN_SEC =
        (16'h0007 << POS_MINUTE_TENS) | (16'h000f << POS_MINUTE_ONES) |
        (16'h0007 << POS_SECOND_TENS) | (16'h000f << POS_SECOND_ONES);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } rtcbv_state_t;

    // Returns the implemented bits of the view that a pointer selects.
    function automatic logic [VIEW_W-1:0] viewMask(input logic [1:0] ptr);
        case (ptr)
            PTR_MIN_SEC:   viewMask = MASK_MIN_SEC;
            PTR_WEEKDAY_DIGIT_HOUR: viewMask = MASK_WEEKDAY_DIGIT_HOUR;
            PTR_MONTH_DAY: viewMask = MASK_MONTH_DAY;
            default:       viewMask = 16'h0000;
        endcase
    endfunction

endpackage

// >>> hw/rtcbv_mem_if.sv
// Interface between the register logic and the value view storage.
// Assumes one write and one registered read port sharing clk.
`timescale 1ns/100ps
interface rtcbv_mem_if;
    import rtcbv_pkg::*;

    logic                we;
    logic [MEM_AW-1:0]   waddr;
    logic [VIEW_W-1:0]   wdata;
    logic                re;
    logic [MEM_AW-1:0]   raddr;
    logic [VIEW_W-1:0]   rdata;

    modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
    modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// >>> hw/rtcbv_view_mem.sv
// Storage for the time and alarm value views, one word per view.
// Assumes the caller masks unimplemented bits; read data is registered.
`timescale 1ns/100ps
module rtcbv_view_mem (
    input wire logic     clk,
    rtcbv_mem_if.store   memBus
);
    import rtcbv_pkg::*;

    logic [VIEW_W-1:0] viewStore [0:MEM_DEPTH-1];
    logic [VIEW_W-1:0] rdData_r;

    // Digits are not reset, so they hold no defined value until software loads them.
    // Each view owns its own word, so writing one never touches another.
    always_ff @(posedge clk) begin
        if (memBus.we) begin
            viewStore[memBus.waddr] <= memBus.wdata;
        end
        if (memBus.re) begin
            rdData_r <= viewStore[memBus.raddr];
        end
    end

    assign memBus.rdata = rdData_r;
endmodule

// >>> hw/rtcbv_view_ptr.sv
// Two-bit view pointer that software loads and each value access steps down.
// Assumes load and step never coincide.
`timescale 1ns/100ps
module rtcbv_view_ptr (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       load,
    input  wire logic [1:0] loadValue,
    input  wire logic       step,
    output logic [1:0]      ptr
);
    import rtcbv_pkg::*;

    logic [1:0] ptr_r;
    logic [1:0] ptr_nxt;

    // The pointer counts down after each access and stops at the minutes/seconds view.
    always_comb begin
        ptr_nxt = ptr_r;
        if (load) begin
            ptr_nxt = loadValue;
        end else if (step && (ptr_r != PTR_MIN_SEC)) begin
            ptr_nxt = ptr_r - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= RST_POINTER;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign ptr = ptr_r;
endmodule

// >>> hw/rtcbv_top.sv
// APB register block for the BCD time and alarm value views of the clock calendar unit.
// Assumes an APB master on clk; views are reached through pointer-selected value ports.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
module rtcbv_top (
    input  wire logic                           clk,
    input  wire logic                           rst_b,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [rtcbv_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [rtcbv_pkg::DATA_W-1:0]   pwdata,
    output logic [rtcbv_pkg::DATA_W-1:0]        prdata,
    output logic                                pready,
    output logic                                pslverr
);
    import rtcbv_pkg::*;

    rtcbv_mem_if memBus ();

    rtcbv_state_t         state_r;
    rtcbv_state_t         state_nxt;
    logic [DATA_W-1:0]    prdata_r;
    logic [DATA_W-1:0]    prdata_nxt;
    logic                 pready_r;
    logic                 pready_nxt;
    logic                 pslverr_r;
    logic                 pslverr_nxt;
    logic                 writeEnable_r;
    logic                 writeEnable_nxt;

    logic                 hitConfig;
    logic                 hitAlarmConfig;
    logic                 hitTime;
    logic                 hitAlarm;
    logic                 hitMapped;
    logic                 commit;
    logic                 viewLocked;
    logic [1:0]           timePtr;
    logic [1:0]           alarmPtr;
    logic [1:0]           viewSel;
    logic [DATA_W-1:0]    readValue;

    assign hitConfig      = (paddr == OFS_CONFIG);
    assign hitAlarmConfig = (paddr == OFS_ALARM_CONFIG);
    assign hitTime        = (paddr == OFS_TIME_VALUE);
    assign hitAlarm       = (paddr == OFS_ALARM_VALUE);
    assign hitMapped      = hitConfig | hitAlarmConfig | hitTime | hitAlarm;

    // The transfer takes effect in the cycle in which pready is high.
    assign commit = (state_r == ST_RESP) && psel && penable;

    // The value port addresses the view chosen by its own pointer.
    assign viewSel = hitAlarm ? alarmPtr : timePtr;

    // Month/day and weekday/hours are locked unless write enable is set.
    assign viewLocked = ((viewSel == PTR_MONTH_DAY) || (viewSel == PTR_WEEKDAY_DIGIT_HOUR)) && !writeEnable_r;

    always_comb begin
        memBus.re    = (state_r == ST_IDLE) && psel && !penable;
        memBus.raddr = {hitAlarm, viewSel};
        // Year view lies outside this block, so writes to it are dropped.
        memBus.we    = commit && pwrite && (hitTime || hitAlarm) && !viewLocked &&
                       (viewSel != PTR_YEAR);
        memBus.waddr = {hitAlarm, viewSel};
        // Only implemented digit bits are stored.
        memBus.wdata = pwdata[VIEW_W-1:0] & viewMask(viewSel);
    end

    rtcbv_view_mem u_viewMem (
        .clk    (clk),
        .memBus (memBus.store)
    );

    rtcbv_view_ptr u_timePtr (
        .clk       (clk),
        .rst_b     (rst_b),
        .load      (commit && pwrite && hitConfig),
        .loadValue (pwdata[POS_POINTER+1:POS_POINTER]),
        .step      (commit && hitTime),
        .ptr       (timePtr)
    );

    rtcbv_view_ptr u_alarmPtr (
        .clk       (clk),
        .rst_b     (rst_b),
        .load      (commit && pwrite && hitAlarmConfig),
        .loadValue (pwdata[POS_POINTER+1:POS_POINTER]),
        .step      (commit && hitAlarm),
        .ptr       (alarmPtr)
    );

    // Read value; the pointer is still the one seen at setup.
    always_comb begin
        readValue = '0;
        if (hitConfig) begin
            readValue[POS_WRITE_ENABLE]              = writeEnable_r;
            readValue[POS_POINTER+1:POS_POINTER]     = timePtr;
        end else if (hitAlarmConfig) begin
            readValue[POS_POINTER+1:POS_POINTER]     = alarmPtr;
        end else if (hitTime || hitAlarm) begin
            readValue[VIEW_W-1:0] = memBus.rdata & viewMask(viewSel);
        end
    end

    always_comb begin
        state_nxt       = state_r;
        prdata_nxt      = prdata_r;
        pready_nxt      = 1'b0;
        pslverr_nxt     = 1'b0;
        writeEnable_nxt = writeEnable_r;
        case (state_r)
            ST_IDLE: begin
                if (psel && !penable) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                state_nxt   = ST_RESP;
                pready_nxt  = 1'b1;
                prdata_nxt  = pwrite ? '0 : readValue;
                pslverr_nxt = !hitMapped;
            end
            ST_RESP: begin
                state_nxt = ST_IDLE;
                if (commit && pwrite && hitConfig) begin
                    writeEnable_nxt = pwdata[POS_WRITE_ENABLE];
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r       <= ST_IDLE;
            prdata_r      <= '0;
            pready_r      <= 1'b0;
            pslverr_r     <= 1'b0;
            writeEnable_r <= RST_WRITE_ENABLE;
        end else begin
            state_r       <= state_nxt;
            prdata_r      <= prdata_nxt;
            pready_r      <= pready_nxt;
            pslverr_r     <= pslverr_nxt;
            writeEnable_r <= writeEnable_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // Checking logic below: a shadow of the last minutes/seconds time write.
    logic [VIEW_W-1:0] msShadow_r;
    logic [VIEW_W-1:0] msShadow_nxt;
    logic              msValid_r;
    logic              msValid_nxt;

    always_comb begin
        msShadow_nxt = msShadow_r;
        msValid_nxt  = msValid_r;
        if (memBus.we && (memBus.waddr == {1'b0, PTR_MIN_SEC})) begin
            msShadow_nxt = memBus.wdata;
            msValid_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            msShadow_r <= '0;
            msValid_r  <= 1'b0;
        end else begin
            msShadow_r <= msShadow_nxt;
            msValid_r  <= msValid_nxt;
        end
    end

    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence seqSetup;
        (state_r == ST_IDLE) && psel && !penable;
    endsequence

    sequence seqAnswer;
        !pready_r ##1 pready_r;
    endsequence

    AST_ANSWER_TIMING: assert property (seqSetup |=> seqAnswer)
        else $error("pready did not rise two cycles after setup");

    AST_TIME_PTR_STEP: assert property (
        (commit && hitTime && (timePtr != PTR_MIN_SEC)) |=> (timePtr == 2'($past(timePtr) - 2'h1)))
        else $error("time pointer did not step down after a value access");

    AST_PTR_STOPS: assert property (
        (commit && hitTime && (timePtr == PTR_MIN_SEC)) |=> (timePtr == PTR_MIN_SEC))
        else $error("time pointer moved below the minutes/seconds view");

    AST_ALARM_PTR_STEP: assert property (
        (commit && hitAlarm) |=> (alarmPtr == (($past(alarmPtr) == PTR_MIN_SEC) ? PTR_MIN_SEC :
                                              2'($past(alarmPtr) - 2'h1))))
        else $error("alarm pointer did not step correctly");

    AST_LOCKED_WRITE: assert property (
        (commit && pwrite && (hitTime || hitAlarm) && !writeEnable_r &&
         ((viewSel == PTR_MONTH_DAY) || (viewSel == PTR_WEEKDAY_DIGIT_HOUR))) |-> !memBus.we)
        else $error("locked view was written while write enable was clear");

    AST_UNIMPL_ZERO: assert property (
        (pready_r && !pwrite && hitTime) |->
        (prdata_r[DATA_W-1:VIEW_W] == '0) && ((prdata_r[VIEW_W-1:0] & ~viewMask(timePtr)) == '0))
        else $error("unimplemented view bit read as one");

    AST_DIGIT_FIELDS: assert property (
        memBus.we |-> ((memBus.wdata & ~viewMask(memBus.waddr[1:0])) == '0))
        else $error("write reached a bit outside the view digit fields");

    AST_VIEW_ADDRESS: assert property (
        memBus.we |-> (memBus.waddr == (hitAlarm ? {1'b1, alarmPtr} : {1'b0, timePtr})))
        else $error("write went to a view other than the selected one");

    AST_READBACK: assert property (
        (pready_r && psel && !pwrite && hitTime && (timePtr == PTR_MIN_SEC) && msValid_r) |->
        (prdata_r[VIEW_W-1:0] == msShadow_r))
        else $error("minutes/seconds view did not read back its last write");

    AST_WRITE_ONCE: assert property (
        memBus.we |-> (state_r == ST_RESP) ##1 !memBus.we)
        else $error("view storage written outside the response cycle");

    // Answer path and register readback checks.
    sequence seqTimeRead;
        (state_r == ST_IDLE) && psel && !penable && !pwrite && hitTime;
    endsequence

    sequence seqUpperZero;
        pready_r && (prdata_r[DATA_W-1:VIEW_W] == '0);
    endsequence

    AST_UPPER_HALF_ZERO: assert property (seqTimeRead |=> ##1 seqUpperZero)
        else $error("upper half of a time view read was not zero");

    // The year view is held elsewhere, so this port shows it as zero.
    AST_YEAR_READS_ZERO: assert property (
        (pready_r && !pwrite && (hitTime || hitAlarm) && (viewSel == PTR_YEAR)) |-> (prdata_r == '0))
        else $error("year view read returned nonzero data");

    // An unmapped address gets an error and no data.
    AST_ERROR_ANSWER: assert property (
        (pready_r && !hitMapped) |-> (pslverr_r && (prdata_r == '0)))
        else $error("unmapped access did not answer with an error and zero data");

    AST_CONFIG_READBACK: assert property (
        (pready_r && !pwrite && hitConfig) |->
        (prdata_r[POS_POINTER+1:POS_POINTER] == timePtr) && (prdata_r[POS_WRITE_ENABLE] == writeEnable_r))
        else $error("config read did not show the time pointer and write enable");

    AST_ALARM_CONFIG_READBACK: assert property (
        (pready_r && !pwrite && hitAlarmConfig) |-> (prdata_r[POS_POINTER+1:POS_POINTER] == alarmPtr))
        else $error("alarm config read did not show the alarm pointer");

    AST_ENABLE_LOAD: assert property (
        (commit && pwrite && hitConfig) |=> (writeEnable_r == $past(pwdata[POS_WRITE_ENABLE])))
        else $error("write enable did not follow the config write");

    // Minutes/seconds stay writable whatever the lock says.
    AST_MIN_SEC_OPEN: assert property (
        (commit && pwrite && (hitTime || hitAlarm) && (viewSel == PTR_MIN_SEC)) |-> memBus.we)
        else $error("minutes/seconds write was dropped");

    AST_OPEN_WRITE: assert property (
        (commit && pwrite && (hitTime || hitAlarm) && writeEnable_r && (viewSel != PTR_YEAR)) |-> memBus.we)
        else $error("view write was dropped while write enable was set");

    AST_ALARM_PTR_STOPS: assert property (
        (commit && hitAlarm && (alarmPtr == PTR_MIN_SEC)) |=> (alarmPtr == PTR_MIN_SEC))
        else $error("alarm pointer moved below the minutes/seconds view");

    // Pointers move only on their own value access or a config load.
    AST_TIME_PTR_HOLD: assert property (
        !(commit && (hitTime || hitConfig)) |=> (timePtr == $past(timePtr)))
        else $error("time pointer moved without an access");

    AST_ALARM_PTR_HOLD: assert property (
        !(commit && (hitAlarm || hitAlarmConfig)) |=> (alarmPtr == $past(alarmPtr)))
        else $error("alarm pointer moved without an access");

endmodule

// >>> tb/tb.sv
// Self-checking bench for the time and alarm value view block, driven over APB.
// Assumes rtcbv_pkg and the design files are compiled first; one 25 MHz clock.
`timescale 1ns/100ps
module tb;
    import rtcbv_pkg::*;

    logic              clk;
    logic              rst_b;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    int                numErrors;
    int                totalChecks;
    logic [31:0]       rd0;

    rtcbv_top i_rtcbv_top (
        .clk     (clk),
        .rst_b   (rst_b),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the answer is taken at the rising edge where pready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic expErr,
                        output logic [31:0] r);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, 32'h0, 32'h1);
            end_of_test();
        end else begin
            chk(32'(n), 32'h2);
            chk({31'h0, pslverr}, {31'h0, expErr});
            r = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, 1'b0, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, 1'b0, r);
    endtask

    // Loads a pointer to month/day and writes three views, unused bits all set.
    task automatic wrViews(input logic [7:0] cfg, input logic [31:0] cfgVal, input logic [7:0] port,
                           input logic [15:0] v0, input logic [15:0] v1, input logic [15:0] v2);
        wr(cfg, cfgVal);
        wr(port, {16'hffff, v0 | ~MASK_MONTH_DAY});
        wr(port, {16'hffff, v1 | ~MASK_WEEKDAY_DIGIT_HOUR});
        wr(port, {16'hffff, v2 | ~MASK_MIN_SEC});
    endtask

    // Walks the three views from month/day down and reads once more at the bottom.
    task automatic rdViews(input logic [7:0] cfg, input logic [31:0] cfgVal, input logic [7:0] port,
                           input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
        logic [31:0] r;
        wr(cfg, cfgVal);
        rd(port, r);
        chk(r, {16'h0, e0});
        rd(port, r);
        chk(r, {16'h0, e1});
        rd(port, r);
        chk(r, {16'h0, e2});
        rd(port, r);
        chk(r, {16'h0, e2});
    endtask

    initial begin
        rst_b       = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        numErrors   = 0;
        totalChecks = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({30'h0, pready, pslverr}, 32'h0);
        chk(prdata, 32'h0);
        rd(OFS_CONFIG, rd0);
        chk(rd0, 32'h0);
        rd(OFS_ALARM_CONFIG, rd0);
        chk(rd0, 32'h0);
        // Digits are unknown after power-on, but unused bits must still read zero.
        rd(OFS_TIME_VALUE, rd0);
        chk(rd0 & ~{16'h0, MASK_MIN_SEC}, 32'h0);
        rd(OFS_ALARM_VALUE, rd0);
        chk(rd0 & ~{16'h0, MASK_MIN_SEC}, 32'h0);

        wrViews(OFS_CONFIG, 32'h2200, OFS_TIME_VALUE, 16'h1231, 16'h0623, 16'h5958);
        wrViews(OFS_ALARM_CONFIG, 32'h0200, OFS_ALARM_VALUE, 16'h1109, 16'h0512, 16'h4530);
        rdViews(OFS_CONFIG, 32'h2200, OFS_TIME_VALUE, 16'h1231, 16'h0623, 16'h5958);
        rdViews(OFS_ALARM_CONFIG, 32'h0200, OFS_ALARM_VALUE, 16'h1109, 16'h0512, 16'h4530);

        // With write enable clear only the minutes/seconds views take new data.
        wrViews(OFS_CONFIG, 32'h0200, OFS_TIME_VALUE, 16'h0915, 16'h0311, 16'h1020);
        wrViews(OFS_ALARM_CONFIG, 32'h0200, OFS_ALARM_VALUE, 16'h0101, 16'h0202, 16'h3344);
        rdViews(OFS_CONFIG, 32'h0200, OFS_TIME_VALUE, 16'h1231, 16'h0623, 16'h1020);
        rdViews(OFS_ALARM_CONFIG, 32'h0200, OFS_ALARM_VALUE, 16'h1109, 16'h0512, 16'h3344);

        // Pointer at the year code reads zero here and then steps to month/day.
        wr(OFS_CONFIG, 32'h0300);
        rd(OFS_TIME_VALUE, rd0);
        chk(rd0, 32'h0);
        rd(OFS_TIME_VALUE, rd0);
        chk(rd0, 32'h1231);
        wr(OFS_ALARM_CONFIG, 32'h0300);
        rd(OFS_ALARM_VALUE, rd0);
        chk(rd0, 32'h0);
        rd(OFS_ALARM_VALUE, rd0);
        chk(rd0, 32'h1109);
        rd(OFS_CONFIG, rd0);
        chk(rd0, 32'h0100);
        rd(OFS_ALARM_CONFIG, rd0);
        chk(rd0, 32'h0100);

        // Unmapped address answers with an error and zero data.
        xfer(1'b0, 8'h10, 32'h0, 1'b1, rd0);
        chk(rd0, 32'h0);
        xfer(1'b1, 8'h14, 32'hffff_ffff, 1'b1, rd0);
        rdViews(OFS_CONFIG, 32'h2200, OFS_TIME_VALUE, 16'h1231, 16'h0623, 16'h1020);
        end_of_test();
    end
endmodule
